// ---- hw/display_port_pkg.sv ----
package display_port_pkg;

  // Interface straps read as {iface_select_high, iface_select_low}.
  typedef enum logic [1:0] {
    MODE_SERIAL = 2'b00,
    MODE_I2C    = 2'b01,
    MODE_6800   = 2'b10,
    MODE_8080   = 2'b11
  } port_mode_t;

  // One received byte together with its command/data flag.
  typedef struct packed {
    logic       dc;
    logic [7:0] data;
  } byte_word_t;

  // Two-wire receiver states.
  typedef enum logic [2:0] {
    I2C_IDLE     = 3'b000,
    I2C_ADDR     = 3'b001,
    I2C_ADDR_ACK = 3'b010,
    I2C_CTRL     = 3'b011,
    I2C_CTRL_ACK = 3'b100,
    I2C_DATA     = 3'b101,
    I2C_DATA_ACK = 3'b110
  } i2c_state_t;

  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [5:0] I2C_ADDR_UPPER = 6'h1e;
  localparam int CTRL_DC_BIT = 6;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

endpackage

// ---- hw/display_host_port.sv ----
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// (R1) Straps pick 6800, 8080, serial or two-wire port; device runs the chosen one.
// (R2) Command/data line low marks a command byte, high marks display data.
// (R3) In 6800 mode read/write high reads, low writes.
// (R4) In 6800 mode an access happens on the falling edge of the enable strobe.
// (R5) In 8080 mode a low pulse on the write strobe writes one byte.
// (R6) In 8080 mode a low read strobe makes the device drive the bus.
// (R7) Parallel modes share an 8-bit bus; device drives it only during reads.
// (R8) Parallel and serial activity is ignored while chip select is high.
// (R9) A low reset input holds the device in reset in every mode.
// (R10) Serial mode: host clocks bytes into the device on one data line; write-only.
// (R11) The address-select pin sets the two-wire target address low bit.
// (R12) Host may join the two-wire data lines or leave the output open.
// (R13) Serial bits sampled on clock rise, MSB first; D/C taken at eighth bit.
// (R14) Host ties unused parallel lines and strobes low; chip select low in two-wire mode.
module display_host_port
  import display_port_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Interface straps and control pins.
  input wire logic iface_select_high,
  input wire logic iface_select_low,
  input wire logic chip_select_n,
  input wire logic data_command,
  input wire logic rw_or_write_n,
  input wire logic enable_or_read_n,
  // Parallel data bus, split into its three parts.
  input wire logic [7:0] parallel_data_bus_i,
  output logic [7:0] parallel_data_bus_o,
  output logic parallel_data_bus_oe,
  // Serial and two-wire pins.
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic target_addr_lsb_select,
  output logic i2c_data_out_o,
  output logic i2c_data_out_oe,
  // Received byte stream toward the controller core.
  output byte_word_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic busy,
  // Read data from the controller core.
  input wire logic [7:0] read_data,
  output logic read_done
);

  function automatic logic fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic rose(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  port_mode_t mode;
  logic cs_active;
  logic in_ready;
  logic push_valid;
  byte_word_t push_word;
  logic push_ok;
  logic pop;

  // Straps are decoded every cycle; they are expected to be static. [R1]
  assign mode = port_mode_t'({iface_select_high, iface_select_low});
  assign cs_active = ~chip_select_n; // [R8]

  // ---------------- Parallel and serial front end ----------------
  logic e_prev_reg, e_prev_next;
  logic w_prev_reg, w_prev_next;
  logic c_prev_reg, c_prev_next;
  logic d_prev_reg, d_prev_next;
  logic drive_reg, drive_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic read_done_reg, read_done_next;
  logic wr6800, rd6800_start, rd6800_done;
  logic wr8080, rd8080_start, rd8080_done;
  logic scl_rise, scl_fall, sda_start, sda_stop;
  logic [7:0] in_byte;

  // Strobe edges; parallel accesses only count with chip select low. [R8]
  always_comb begin
    wr6800 = (mode == MODE_6800) && cs_active && !rw_or_write_n
             && fell(e_prev_reg, enable_or_read_n); // [R3] [R4]
    rd6800_start = (mode == MODE_6800) && cs_active && rw_or_write_n
                   && rose(e_prev_reg, enable_or_read_n); // [R3]
    rd6800_done = (mode == MODE_6800) && cs_active && rw_or_write_n
                  && fell(e_prev_reg, enable_or_read_n); // [R4]
    wr8080 = (mode == MODE_8080) && cs_active
             && rose(w_prev_reg, rw_or_write_n); // [R5]
    rd8080_start = (mode == MODE_8080) && cs_active
                   && fell(d_prev_reg, enable_or_read_n); // [R6]
    rd8080_done = (mode == MODE_8080) && cs_active
                  && rose(d_prev_reg, enable_or_read_n); // [R6]
    scl_rise = rose(c_prev_reg, serial_clock);
    scl_fall = fell(c_prev_reg, serial_clock);
    sda_start = serial_clock && c_prev_reg && fell(w_prev_reg, serial_data_in);
    sda_stop = serial_clock && c_prev_reg && rose(w_prev_reg, serial_data_in);
  end

  // Bus direction and read data; the bus is driven only inside a read. [R7]
  always_comb begin
    e_prev_next = enable_or_read_n;
    d_prev_next = enable_or_read_n;
    c_prev_next = serial_clock;
    w_prev_next = (mode == MODE_8080) ? rw_or_write_n : serial_data_in;
    drive_next = ((mode == MODE_6800) && cs_active && rw_or_write_n && enable_or_read_n)
                 || ((mode == MODE_8080) && cs_active && !enable_or_read_n); // [R3] [R6]
    rd_data_next = (rd6800_start || rd8080_start) ? read_data : rd_data_reg;
    read_done_next = rd6800_done || rd8080_done; // [R4]
  end

  // Reset holds every front-end flop whatever the mode. [R9]
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      e_prev_reg <= 1'b1;
      w_prev_reg <= 1'b1;
      c_prev_reg <= 1'b0;
      d_prev_reg <= 1'b1;
      drive_reg <= 1'b0;
      rd_data_reg <= READ_DATA_RESET;
      read_done_reg <= 1'b0;
    end else begin
      e_prev_reg <= e_prev_next;
      w_prev_reg <= w_prev_next;
      c_prev_reg <= c_prev_next;
      d_prev_reg <= d_prev_next;
      drive_reg <= drive_next;
      rd_data_reg <= rd_data_next;
      read_done_reg <= read_done_next;
    end
  end

  assign parallel_data_bus_o = rd_data_reg;
  assign parallel_data_bus_oe = drive_reg;
  assign read_done = read_done_reg;

  // ---------------- Serial shifter and two-wire receiver ----------------
  logic [6:0] shift_reg, shift_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  i2c_state_t i2c_state_reg, i2c_state_next;
  logic ack_ok_reg, ack_ok_next;
  logic ack_drive_reg, ack_drive_next;
  logic i2c_dc_reg, i2c_dc_next;
  logic ser_push, i2c_push, byte_done;
  logic i2c_receiving;

  assign in_byte = {shift_reg, serial_data_in};
  assign i2c_receiving = (i2c_state_reg == I2C_ADDR) || (i2c_state_reg == I2C_CTRL)
                         || (i2c_state_reg == I2C_DATA);

  // One shifter serves both serial modes since only one is strapped at a time.
  always_comb begin
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    i2c_state_next = i2c_state_reg;
    ack_ok_next = ack_ok_reg;
    ack_drive_next = ack_drive_reg;
    i2c_dc_next = i2c_dc_reg;
    ser_push = 1'b0;
    i2c_push = 1'b0;
    byte_done = scl_rise && (bit_cnt_reg == BIT_LAST);
    if (mode == MODE_SERIAL) begin
      i2c_state_next = I2C_IDLE;
      ack_drive_next = 1'b0;
      if (!cs_active) begin
        bit_cnt_next = BIT_FIRST; // [R8]
      end else if (scl_rise) begin
        shift_next = in_byte[6:0]; // [R10] [R13]
        bit_cnt_next = bit_cnt_reg + 3'h1;
        ser_push = byte_done; // [R13]
      end
    end else if (mode == MODE_I2C) begin
      if (sda_start) begin
        i2c_state_next = I2C_ADDR;
        bit_cnt_next = BIT_FIRST;
        ack_drive_next = 1'b0;
      end else if (sda_stop) begin
        i2c_state_next = I2C_IDLE;
        ack_drive_next = 1'b0;
      end else if (scl_rise && i2c_receiving) begin
        shift_next = in_byte[6:0];
        bit_cnt_next = bit_cnt_reg + 3'h1;
        if (byte_done) begin
          case (i2c_state_reg)
            I2C_ADDR: begin
              // Write-only target; a read address is left unanswered.
              ack_ok_next = (in_byte[7:1] == {I2C_ADDR_UPPER, target_addr_lsb_select})
                            && !in_byte[0]; // [R11]
              i2c_state_next = I2C_ADDR_ACK;
            end
            I2C_CTRL: begin
              i2c_dc_next = in_byte[CTRL_DC_BIT];
              ack_ok_next = 1'b1;
              i2c_state_next = I2C_CTRL_ACK;
            end
            default: begin
              // A full buffer answers with a missing acknowledge.
              i2c_push = in_ready;
              ack_ok_next = in_ready;
              i2c_state_next = I2C_DATA_ACK;
            end
          endcase
        end
      end else if (scl_fall && !i2c_receiving && (i2c_state_reg != I2C_IDLE)) begin
        if (!ack_drive_reg && ack_ok_reg) begin
          ack_drive_next = 1'b1;
        end else begin
          ack_drive_next = 1'b0;
          bit_cnt_next = BIT_FIRST;
          case (i2c_state_reg)
            I2C_ADDR_ACK: i2c_state_next = ack_ok_reg ? I2C_CTRL : I2C_IDLE;
            I2C_CTRL_ACK: i2c_state_next = I2C_DATA;
            I2C_DATA_ACK: i2c_state_next = ack_ok_reg ? I2C_DATA : I2C_IDLE;
            default: i2c_state_next = I2C_IDLE;
          endcase
        end
      end
    end else begin
      i2c_state_next = I2C_IDLE;
      ack_drive_next = 1'b0;
      bit_cnt_next = BIT_FIRST;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= BIT_FIRST;
      i2c_state_reg <= I2C_IDLE;
      ack_ok_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      i2c_dc_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      i2c_state_reg <= i2c_state_next;
      ack_ok_reg <= ack_ok_next;
      ack_drive_reg <= ack_drive_next;
      i2c_dc_reg <= i2c_dc_next;
    end
  end

  // Open-drain acknowledge: the line is only ever pulled low.
  assign i2c_data_out_o = 1'b0;
  assign i2c_data_out_oe = ack_drive_reg;

  // Source selection; the command/data level rides with each byte. [R2]
  always_comb begin
    push_valid = wr6800 || wr8080 || ser_push || i2c_push;
    push_word.dc = (mode == MODE_I2C) ? i2c_dc_reg : data_command;
    push_word.data = ((mode == MODE_6800) || (mode == MODE_8080)) ?
                     parallel_data_bus_i : in_byte;
  end

  // ---------------- Two-entry buffer ----------------
  byte_word_t mem_reg [BUF_DEPTH];
  byte_word_t mem_next [BUF_DEPTH];
  logic wr_ptr_reg, wr_ptr_next;
  logic rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;

  assign in_ready = (count_reg != BUF_FULL);
  assign busy = ~in_ready;
  assign rx_valid = (count_reg != 2'h0);
  assign rx_word = mem_reg[rd_ptr_reg];
  assign push_ok = push_valid && in_ready;
  assign pop = rx_valid && rx_ready;

  // A parallel byte that meets a full buffer is lost, so hosts watch busy.
  always_comb begin
    mem_next = mem_reg;
    if (push_ok) begin
      mem_next[wr_ptr_reg] = push_word;
    end
    wr_ptr_next = wr_ptr_reg ^ push_ok;
    rd_ptr_next = rd_ptr_reg ^ pop;
    count_next = count_reg + {1'b0, push_ok} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence rd8080_held;
    (mode == MODE_8080) && cs_active && !enable_or_read_n [*2];
  endsequence

  sequence addr_accepted;
    (i2c_state_reg == I2C_ADDR) ##1 (i2c_state_reg == I2C_ADDR_ACK) && ack_ok_reg;
  endsequence

  a_serial_mode_quiet: assert property ( // [R1]
    (mode == MODE_SERIAL || mode == MODE_I2C) |=> !parallel_data_bus_oe)
    else $error("parallel bus driven in a serial mode");
  a_dc_with_byte: assert property ( // [R2]
    push_ok && (mode != MODE_I2C) |=> mem_reg[$past(wr_ptr_reg)].dc == $past(data_command))
    else $error("command/data flag not stored with byte");
  a_write_no_drive: assert property ( // [R3]
    (mode == MODE_6800) && !rw_or_write_n |=> !parallel_data_bus_oe)
    else $error("bus driven during 6800 write");
  a_strobe_fall_take: assert property ( // [R4]
    wr6800 && in_ready |=> rx_valid && count_reg == $past(count_reg) + 2'h1 - {1'b0, $past(pop)})
    else $error("6800 falling strobe did not store a byte");
  a_write_8080_data: assert property ( // [R5]
    wr8080 && in_ready |=> mem_reg[$past(wr_ptr_reg)].data == $past(parallel_data_bus_i))
    else $error("8080 write data not stored");
  a_read_drives_bus: assert property ( // [R6] [R7]
    rd8080_held |-> parallel_data_bus_oe)
    else $error("bus not driven during 8080 read");
  a_cs_ignores_bus: assert property ( // [R8]
    chip_select_n && (mode != MODE_I2C) |-> !push_valid)
    else $error("byte accepted with chip select high");
  a_serial_msb_first: assert property ( // [R10] [R13]
    ser_push |-> push_word.data[7:1] == shift_reg && bit_cnt_reg == BIT_LAST)
    else $error("serial byte assembled wrongly");
  a_addr_lsb_match: assert property ( // [R11]
    addr_accepted |-> $past(in_byte[1]) == $past(target_addr_lsb_select))
    else $error("address acknowledged with wrong low bit");

endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model
  import display_port_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Pins toward the device.
  output logic chip_select_n,
  output logic data_command,
  output logic rw_or_write_n,
  output logic enable_or_read_n,
  output logic [7:0] bus_in,
  output logic serial_clock,
  output logic serial_data_in,
  // Pins from the device.
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic sda_oe,
  input wire logic sda_o
);
  logic drive = 1'b0;
  logic sda_low = 1'b0;
  logic i2c_on = 1'b0;
  logic serial_bit = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] float_q = 8'h5a;

  // A released bus shows a changing pattern, so a stale value never reads as good.
  always @(posedge ref_clk) float_q <= ~float_q;
  assign bus_in = drive ? wdata : (bus_oe ? bus_out : float_q);
  // The joined two-wire data line is pulled up; either side may pull it low.
  assign serial_data_in = i2c_on ? ~(sda_low | (sda_oe & ~sda_o)) : serial_bit;

  // Idle levels: 6800 enable low, 8080 write strobe high, serial clock still.
  initial begin
    chip_select_n = 1'b1;
    data_command = 1'b0;
    rw_or_write_n = 1'b1;
    enable_or_read_n = 1'b0;
    serial_clock = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic idle(input port_mode_t m);
    chip_select_n = 1'b1;
    drive = 1'b0;
    i2c_on = 1'b0;
    serial_clock = 1'b0;
    rw_or_write_n = 1'b1;
    enable_or_read_n = (m == MODE_8080);
  endtask

  // One parallel write; everything is held past the strobe edge that takes it.
  task automatic par_write(input port_mode_t m, input logic sel, input logic dc,
                           input logic [7:0] d);
    chip_select_n = ~sel;
    data_command = dc;
    wdata = d;
    drive = 1'b1;
    rw_or_write_n = 1'b0;
    if (m != MODE_8080) enable_or_read_n = 1'b1;
    step(1);
    if (m == MODE_8080) rw_or_write_n = 1'b1;
    else enable_or_read_n = 1'b0;
    step(1);
    drive = 1'b0;
    chip_select_n = 1'b1;
    rw_or_write_n = 1'b1;
    step(1);
  endtask

  // One parallel read; the byte is taken while the device still drives it.
  task automatic par_read(input port_mode_t m, output logic [7:0] d, output logic oe);
    chip_select_n = 1'b0;
    enable_or_read_n = (m != MODE_8080);
    step(3);
    d = bus_in;
    oe = bus_oe;
    enable_or_read_n = (m == MODE_8080);
    step(1);
    chip_select_n = 1'b1;
    step(3);
  endtask

  // Serial byte, MSB first, data changed while the clock is low.
  task automatic ser_byte(input logic dc, input logic [7:0] d);
    chip_select_n = 1'b0;
    data_command = dc;
    for (int i = 7; i >= 0; i--) begin
      serial_bit = d[i];
      step(1);
      serial_clock = 1'b1;
      step(1);
      serial_clock = 1'b0;
    end
    step(1);
    chip_select_n = 1'b1;
    step(1);
  endtask

  task automatic i2c_start();
    i2c_on = 1'b1;
    chip_select_n = 1'b0;
    wdata = 8'h00;
    drive = 1'b1;
    rw_or_write_n = 1'b0;
    enable_or_read_n = 1'b0;
    sda_low = 1'b0;
    serial_clock = 1'b1;
    step(2);
    sda_low = 1'b1;
    step(1);
    serial_clock = 1'b0;
    step(1);
  endtask

  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~d[i];
      step(1);
      serial_clock = 1'b1;
      step(1);
      serial_clock = 1'b0;
    end
    sda_low = 1'b0;
    step(2);
    serial_clock = 1'b1;
    step(1);
    ack = ~serial_data_in;
    serial_clock = 1'b0;
    step(2);
  endtask

  task automatic i2c_stop();
    sda_low = 1'b1;
    step(1);
    serial_clock = 1'b1;
    step(1);
    sda_low = 1'b0;
    step(2);
  endtask
endmodule
`default_nettype wire

// ---- tb/display_host_port_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module display_host_port_test import display_port_pkg::*;;
  logic ref_clk;
  logic reset_n;
  logic rx_ready;
  logic lsb;
  logic [7:0] rd_data;
  port_mode_t mode;
  logic sda_o;
  port_mode_t pm[2] = '{MODE_6800, MODE_8080};
  logic [7:0] bus_i, bus_o, got, d;
  logic cs_n, dc, rw, en, sclk, sdi, bus_oe, sda_oe, rx_valid, busy, read_done, oe, ack;
  byte_word_t rx_word;
  byte_word_t exp_q[$];
  int fail_count = 0, num_checks = 0, dones = 0, cycles = 0, n_rd = 0;
  logic [31:0] seed = 32'h00002fdd;

  display_host_port dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .iface_select_high(mode[1]), .iface_select_low(mode[0]), .chip_select_n(cs_n),
    .data_command(dc), .rw_or_write_n(rw), .enable_or_read_n(en),
    .parallel_data_bus_i(bus_i), .parallel_data_bus_o(bus_o), .parallel_data_bus_oe(bus_oe),
    .serial_clock(sclk), .serial_data_in(sdi), .target_addr_lsb_select(lsb),
    .i2c_data_out_o(sda_o), .i2c_data_out_oe(sda_oe), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .busy(busy), .read_data(rd_data), .read_done(read_done));
  host_model host_u (.ref_clk(ref_clk), .chip_select_n(cs_n), .data_command(dc),
    .rw_or_write_n(rw), .enable_or_read_n(en), .bus_in(bus_i), .serial_clock(sclk),
    .serial_data_in(sdi), .bus_out(bus_o), .bus_oe(bus_oe), .sda_oe(sda_oe), .sda_o(sda_o));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic fail(input string msg);
    fail_count++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk_word(input byte_word_t g, input byte_word_t w);
    num_checks++;
    if (g !== w) fail("received word differs");
  endtask

  task automatic chk_bit(input logic g, input logic w);
    num_checks++;
    if (g !== w) fail("flag differs");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Every word the core accepts must be the oldest one still expected; a hang is cut off.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (read_done === 1'b1) dones <= dones + 1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) fail("word not expected");
      else chk_word(rx_word, exp_q.pop_front());
    end
    if (cycles == 20000) begin
      fail("timeout");
      end_of_test();
    end
  end

  initial begin
    // Start values are driven here so that every design input stays a stimulus.
    reset_n = 1'b0;
    rx_ready = 1'b1;
    lsb = 1'b0;
    rd_data = 8'h00;
    mode = MODE_6800;
    host_u.step(10);
    reset_n = 1'b1;
    host_u.step(2);
    // Writes with and without chip select, then a read, in both parallel modes.
    foreach (pm[k]) begin
      mode = pm[k];
      host_u.idle(mode);
      host_u.step(2);
      for (int i = 0; i < 3; i++) begin
        d = rnd();
        if (i < 2) exp_q.push_back({i[0], d});
        host_u.par_write(mode, i < 2, i[0], d);
      end
      rd_data = rnd();
      host_u.par_read(mode, got, oe);
      chk_word({1'b0, got}, {1'b0, rd_data});
      chk_bit(oe, 1'b1);
      chk_bit(bus_oe, 1'b0);
      n_rd++;
      chk_bit(dones == n_rd, 1'b1);
    end
    // Core stalls: the third byte finds the buffer full and is lost.
    rx_ready = 1'b0;
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      if (i < 2) exp_q.push_back({1'b1, d});
      host_u.par_write(mode, 1'b1, 1'b1, d);
    end
    chk_bit(busy, 1'b1);
    rx_ready = 1'b1;
    host_u.step(4);
    chk_bit(busy, 1'b0);
    // A reset in mid-run empties the buffer at once.
    rx_ready = 1'b0;
    host_u.par_write(mode, 1'b1, 1'b0, rnd());
    reset_n = 1'b0;
    host_u.step(1);
    chk_bit(rx_valid, 1'b0);
    chk_bit(bus_oe, 1'b0);
    reset_n = 1'b1;
    rx_ready = 1'b1;
    host_u.step(2);
    // Serial bytes with random command/data flags.
    mode = MODE_SERIAL;
    host_u.idle(mode);
    host_u.step(2);
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      exp_q.push_back({d[3], d});
      host_u.ser_byte(d[3], d);
    end
    // Two-wire: matching address, control byte, data; then the wrong address.
    mode = MODE_I2C;
    d = rnd();
    lsb = d[0];
    host_u.i2c_start();
    host_u.i2c_byte({I2C_ADDR_UPPER, lsb, 1'b0}, ack);
    chk_bit(ack, 1'b1);
    host_u.i2c_byte(8'h40, ack);
    d = rnd();
    exp_q.push_back({1'b1, d});
    host_u.i2c_byte(d, ack);
    chk_bit(ack, 1'b1);
    host_u.i2c_stop();
    host_u.i2c_start();
    host_u.i2c_byte({I2C_ADDR_UPPER, ~lsb, 1'b0}, ack);
    chk_bit(ack, 1'b0);
    host_u.i2c_stop();
    host_u.step(10);
    chk_bit(exp_q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
